// File: hdl/tcpio_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes: one clock; entries are flip-flops
`default_nettype none

module tcpio_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                mem_ff[i] <= '0;
            end else if (push && (wr_ptr_ff == PW'(i))) begin
                mem_ff[i] <= in_data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_ff + 1'b1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_ff + 1'b1);
            end
            if (push && !pop) begin
                count_ff <= CW'(count_ff + 1'b1);
            end else if (pop && !push) begin
                count_ff <= CW'(count_ff - 1'b1);
            end
        end
    end

endmodule : tcpio_fifo

`default_nettype wire

// File: hdl/tcpio_sync.sv
// two-stage synchroniser for a group of level inputs
// assumes: inputs are levels from outside the clock domain
`default_nettype none

module tcpio_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds the second stage only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : tcpio_sync

`default_nettype wire

// File: hdl/tcpio_top.sv
// two-channel parallel handshake port
// assumes: one 20 MHz clock; equipment lines are asynchronous levels
//
// What this block does
// RULE_01: channel zero carries six bits
// RULE_02: channel one carries fifteen bits
// RULE_03: all words pass the transfer register
// RULE_04: static levels, no timeout
// RULE_05: requests in, acknowledges out
// RULE_06: interrupt with input, function with output
// RULE_07: input loads register, raises acknowledge
// RULE_08: equipment releases after acknowledge
// RULE_09: input handshake repeats per word
// RULE_10: interrupt code before interrupt line
// RULE_11: interrupt code loads, raises acknowledge
// RULE_12: interrupt drops after acknowledge
// RULE_13: no interrupt over unanswered request
// RULE_14: later acknowledge answers the interrupt
// RULE_15: output request gets output acknowledge
// RULE_16: equipment samples data on acknowledge
// RULE_17: output handshake repeats per word
// RULE_18: function line marks a command
// RULE_19: later request confirms a function
// RULE_20: code 12 designators 0, 1, 3
// RULE_21: code 16 jumps on absent level
// RULE_22: instruction low bit picks channel
// RULE_23: register drives both channels' lines
// RULE_24: channel zero strobes, channel one flop
// RULE_25: channel one line holds one memory cycle
// RULE_26: output acknowledge drops with request
// RULE_27: one equipment active at once
// RULE_28: two synchroniser stages on levels
`include "tcpio_defs.svh"
`default_nettype none

module tcpio_top #(
    parameter int FUNC_HOLD_CYCLES = `TCPIO_FUNC_HOLD_CYC,
    parameter int FIFO_DEPTH       = `TCPIO_FIFO_DEPTH
) (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    // instruction port
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire logic [5:0]             cmd_func,
    input  wire logic [1:0]             cmd_desig,
    input  wire logic                   cmd_chan,
    output logic                        jump_valid,
    output logic                        jump_taken,
    // transfer register access
    input  wire logic                   q_wr_valid,
    input  wire tcpio_pkg::tcpio_word_type q_wr_data,
    output tcpio_pkg::tcpio_word_type   q_value,
    // input words toward the processor
    output logic                        rx_valid,
    input  wire logic                   rx_ready,
    output tcpio_pkg::tcpio_word_type   rx_data,
    // channel zero
    input  wire tcpio_pkg::tcpio_char_type ch0_in_data,
    input  wire logic                   ch0_in_req,
    input  wire logic                   ch0_intr,
    input  wire logic                   ch0_out_req,
    output tcpio_pkg::tcpio_char_type   ch0_out_data,
    output logic                        ch0_in_ack,
    output logic                        ch0_out_ack,
    output logic                        ch0_func_line,
    // channel one
    input  wire tcpio_pkg::tcpio_word_type ch1_in_data,
    input  wire logic                   ch1_in_req,
    input  wire logic                   ch1_intr,
    input  wire logic                   ch1_out_req,
    output tcpio_pkg::tcpio_word_type   ch1_out_data,
    output logic                        ch1_in_ack,
    output logic                        ch1_out_ack,
    output logic                        ch1_func_line
);
    import tcpio_pkg::*;

    localparam int TW = $clog2(FUNC_HOLD_CYCLES + 1);

    // ============================================================
    // synchronised equipment levels
    logic [5:0]      line_sync;
    logic            in_req_any;
    logic            out_req_any;
    logic            intr_any;

    tcpio_sync #(
        .WIDTH    (6)
    ) u_sync (                                         // see RULE_28
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in ({ch1_intr, ch0_intr, ch1_out_req,
                    ch0_out_req, ch1_in_req, ch0_in_req}),
        .sync_out (line_sync)
    );

    // both channels share one request sense, so the program keeps one active
    assign in_req_any  = line_sync[0] | line_sync[1];  // see RULE_27
    assign out_req_any = line_sync[2] | line_sync[3];
    assign intr_any    = line_sync[4] | line_sync[5];

    // ============================================================
    // instruction decode
    tcpio_state_type state_ff;
    tcpio_state_type nxt_state;
    logic            is_xfer;
    logic            is_jump;
    logic            do_in;
    logic            do_out;
    logic            do_fn;
    logic            accept;
    logic            fifo_in_ready;
    tcpio_word_type  load_word;

    assign is_xfer = (cmd_func == `TCPIO_F_XFER);
    assign is_jump = (cmd_func == `TCPIO_F_JUMP);
    assign do_in   = is_xfer && (cmd_desig == `TCPIO_J_IN);    // see RULE_20
    assign do_out  = is_xfer && (cmd_desig == `TCPIO_J_OUT);
    assign do_fn   = is_xfer && (cmd_desig == `TCPIO_J_FUNC);

    // an input stalls while the buffer toward the processor is full
    assign cmd_ready = (state_ff == TCPIO_ST_IDLE) && !(do_in && !fifo_in_ready);
    assign accept    = cmd_valid && cmd_ready;

    // channel zero words sit in the low bits, upper bits cleared
    assign load_word = cmd_chan ? ch1_in_data                   // see RULE_02
                                : {{(`TCPIO_CH1_WIDTH-`TCPIO_CH0_WIDTH){1'b0}}, ch0_in_data}; // see RULE_01

    // ============================================================
    // transfer register
    tcpio_word_type  q_ff;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= `TCPIO_Q_RESET;
        end else if (accept && do_in) begin
            q_ff <= load_word; // see RULE_03
        end else if (q_wr_valid) begin
            q_ff <= q_wr_data;
        end
    end

    // register reaches both channels' lines; control lines pick the listener
    assign q_value      = q_ff;
    assign ch1_out_data = q_ff; // see RULE_23
    assign ch0_out_data = q_ff[`TCPIO_CH0_WIDTH-1:0];

    tcpio_fifo #(
        .WIDTH     (`TCPIO_CH1_WIDTH),
        .DEPTH     (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .in_valid  (accept && do_in),
        .in_ready  (fifo_in_ready),
        .in_data   (load_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ============================================================
    // input acknowledge: answers a data request or an interrupt alike
    logic [1:0]      in_ack_ff;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_ack_ff <= 2'h0;
        end else if (accept && do_in) begin
            in_ack_ff <= cmd_chan ? 2'h2 : 2'h1; // see RULE_07 RULE_11 RULE_14
        end else if (!in_req_any && !intr_any) begin
            in_ack_ff <= 2'h0; // see RULE_09 RULE_04
        end
    end

    assign ch0_in_ack = in_ack_ff[0]; // see RULE_05
    assign ch1_in_ack = in_ack_ff[1];

    // ============================================================
    // output acknowledge: held until the request returns low
    logic [1:0]      out_ack_ff;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_ack_ff <= 2'h0;
        end else if (accept && do_out) begin
            out_ack_ff <= cmd_chan ? 2'h2 : 2'h1; // see RULE_15 RULE_22
        end else if (!out_req_any) begin
            out_ack_ff <= 2'h0; // see RULE_26 RULE_17
        end
    end

    assign ch0_out_ack = out_ack_ff[0]; // see RULE_18
    assign ch1_out_ack = out_ack_ff[1];

    // ============================================================
    // function lines
    logic            fn0_stb_ff;
    logic            fn1_line_ff;
    logic [TW-1:0]   fn_timer_ff;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fn0_stb_ff <= 1'b0;
        end else begin
            fn0_stb_ff <= accept && do_fn && !cmd_chan; // see RULE_24
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TCPIO_ST_IDLE: begin
                if (accept && do_fn && cmd_chan) begin
                    nxt_state = TCPIO_ST_FUNC;
                end
            end
            TCPIO_ST_FUNC: begin
                if (fn_timer_ff == '0) begin
                    nxt_state = TCPIO_ST_IDLE;
                end
            end
            default: begin
                nxt_state = TCPIO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= TCPIO_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the line stays up for a full memory cycle; commands wait meanwhile
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fn1_line_ff <= 1'b0;
            fn_timer_ff <= '0;
        end else if (state_ff == TCPIO_ST_IDLE && nxt_state == TCPIO_ST_FUNC) begin
            fn1_line_ff <= 1'b1; // see RULE_24
            fn_timer_ff <= TW'(FUNC_HOLD_CYCLES - 1);
        end else if (state_ff == TCPIO_ST_FUNC) begin
            if (fn_timer_ff == '0) begin
                fn1_line_ff <= 1'b0; // see RULE_25
            end else begin
                fn_timer_ff <= TW'(fn_timer_ff - 1'b1);
            end
        end
    end

    assign ch0_func_line = fn0_stb_ff; // see RULE_06
    assign ch1_func_line = fn1_line_ff;

    // ============================================================
    // jump tests; a pending acknowledge masks a still-present request
    logic            jump_valid_ff;
    logic            jump_taken_ff;
    logic            nxt_taken;

    always_comb begin
        case (cmd_desig)
            `TCPIO_J_IN:   nxt_taken = !in_req_any || (in_ack_ff != 2'h0);
            `TCPIO_J_OUT:  nxt_taken = !out_req_any || (out_ack_ff != 2'h0);
            `TCPIO_J_INTR: nxt_taken = !intr_any || (in_ack_ff != 2'h0);
            default:       nxt_taken = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            jump_valid_ff <= 1'b0;
            jump_taken_ff <= 1'b0;
        end else begin
            jump_valid_ff <= accept && is_jump; // see RULE_21
            jump_taken_ff <= accept && is_jump && nxt_taken;
        end
    end

    assign jump_valid = jump_valid_ff;
    assign jump_taken = jump_taken_ff;

    // ============================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_in_ack_raise: assert property ( // see RULE_07
        accept && do_in |=> in_ack_ff == ($past(cmd_chan) ? 2'h2 : 2'h1))
        else $error("input ack not raised");

    chk_in_ack_hold: assert property ( // see RULE_04
        in_ack_ff != 2'h0 && (in_req_any || intr_any)
        |=> in_ack_ff != 2'h0)
        else $error("input ack dropped early");

    chk_ch1_load: assert property ( // see RULE_02
        accept && do_in && cmd_chan |=> q_ff == $past(ch1_in_data))
        else $error("channel one word not loaded");

    chk_ch0_load: assert property ( // see RULE_01
        accept && do_in && !cmd_chan |=> q_ff == {9'h000, $past(ch0_in_data)})
        else $error("channel zero word not loaded");

    chk_rx_push: assert property ( // see RULE_03
        accept && do_in |=> rx_valid)
        else $error("input word not buffered");

    chk_out_ack_raise: assert property ( // see RULE_15
        accept && do_out |=> (ch0_out_ack ^ ch1_out_ack))
        else $error("output ack not raised");

    chk_out_ack_drop: assert property ( // see RULE_26
        out_ack_ff != 2'h0 && !out_req_any && !(accept && do_out)
        |=> out_ack_ff == 2'h0)
        else $error("output ack held after request fell");

    chk_fn0_strobe: assert property ( // see RULE_24
        accept && do_fn && !cmd_chan |=> ch0_func_line ##1 !ch0_func_line)
        else $error("channel zero strobe not one cycle");

    chk_fn_lines_apart: assert property ( // see RULE_24
        ch1_func_line |-> !ch0_func_line)
        else $error("both function lines high");

    chk_fn1_hold: assert property ( // see RULE_25
        $rose(ch1_func_line) |-> ch1_func_line[*8] ##0 !cmd_ready)
        else $error("channel one function line too short");

    chk_fn1_end: assert property ( // see RULE_25
        state_ff == TCPIO_ST_FUNC && fn_timer_ff == '0
        |=> !ch1_func_line && cmd_ready == !(do_in && !fifo_in_ready))
        else $error("channel one function line not ended");

    chk_jump_answer: assert property ( // see RULE_21
        accept && is_jump && cmd_desig == `TCPIO_J_OUT && out_ack_ff != 2'h0
        |=> jump_valid && jump_taken)
        else $error("output jump not taken while ack pending");

endmodule : tcpio_top

`default_nettype wire

// File: include/tcpio_defs.svh
// constants of the two-channel parallel handshake port
// assumes: included by bare name wherever the numbers are needed
`ifndef TCPIO_DEFS_SVH
`define TCPIO_DEFS_SVH

// ============================================================
// widths of the two channels
`define TCPIO_CH0_WIDTH       6
`define TCPIO_CH1_WIDTH       15

// ============================================================
// instruction function codes and designators
`define TCPIO_F_XFER          6'h0A
`define TCPIO_F_JUMP          6'h0E
`define TCPIO_J_IN            2'h0
`define TCPIO_J_OUT           2'h1
`define TCPIO_J_INTR          2'h2
`define TCPIO_J_FUNC          2'h3

// ============================================================
// timing
`define TCPIO_CLK_PERIOD_NS   50
`define TCPIO_FUNC_HOLD_NS    8000
`define TCPIO_FUNC_HOLD_CYC   ((`TCPIO_FUNC_HOLD_NS + `TCPIO_CLK_PERIOD_NS - 1) / `TCPIO_CLK_PERIOD_NS)

// ============================================================
// buffering and reset values
`define TCPIO_FIFO_DEPTH      4
`define TCPIO_Q_RESET         15'h0000

`endif

// File: include/tcpio_pkg.sv
// types shared by the handshake port files
// assumes: tcpio_defs.svh is on the include path
`include "tcpio_defs.svh"
`default_nettype none

package tcpio_pkg;

    typedef logic [`TCPIO_CH1_WIDTH-1:0] tcpio_word_type;
    typedef logic [`TCPIO_CH0_WIDTH-1:0] tcpio_char_type;

    typedef enum logic [1:0] {
        TCPIO_ST_IDLE = 2'b01,
        TCPIO_ST_FUNC = 2'b10
    } tcpio_state_type;

endpackage : tcpio_pkg

`default_nettype wire

// File: verification/tcpio_equip.sv
// behavioural model of one piece of external equipment on one channel
// assumes: one activity on one channel at a time
`default_nettype none

module tcpio_equip #(
    parameter int W = 15
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         in_ack,
    input  wire logic         out_ack,
    input  wire logic [W-1:0] out_data,
    output var  logic [W-1:0] in_data,
    output var  logic         in_req,
    output var  logic         intr,
    output var  logic         out_req
);
    timeunit 1ns;
    timeprecision 1ns;

    // ============================================================
    // state; lag makes the equipment answer slowly
    int           lag;
    int           cnt;
    logic [W-1:0] got;

    initial begin
        lag     = 0;
        in_data = '0;
        in_req  = 1'b0;
        intr    = 1'b0;
        out_req = 1'b0;
        got     = '0;
    end

    // ============================================================
    // mode 0 data word, 1 interrupt, 2 emergency switch from a pending request
    // in mode 2 the unanswered request is dropped a cycle before the interrupt rises
    task automatic put_word(input logic [W-1:0] w, input int mode);
        @(posedge core_clk);
        in_data <= w;
        in_req  <= 1'b0;
        @(posedge core_clk);
        if (mode == 0) in_req <= 1'b1;
        else intr <= 1'b1;
    endtask : put_word

    // no receipt for a function command: a later request is the only answer
    task automatic want_word();
        @(posedge core_clk);
        out_req <= 1'b1;
    endtask : want_word

    // ============================================================
    // levels are held until the answer comes, however long
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
        end else if (in_ack && (in_req || intr)) begin
            cnt <= cnt + 1;
            if (cnt >= lag) begin
                in_req  <= 1'b0;
                intr    <= 1'b0;
                in_data <= ~in_data;
                cnt     <= 0;
            end
        end else if (out_ack && out_req) begin
            got <= out_data;
            cnt <= cnt + 1;
            if (cnt >= lag) begin
                out_req <= 1'b0;
                cnt     <= 0;
            end
        end
    end
endmodule : tcpio_equip

`default_nettype wire

// File: verification/tcpio_top_bench.sv
// self-checking bench of the two-channel handshake port
// assumes: tcpio_top, tcpio_fifo, tcpio_sync and tcpio_equip are compiled
`include "tcpio_defs.svh"
`default_nettype none

module tcpio_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tcpio_pkg::*;

    // ============================================================
    // signals; a short function hold keeps the run brief
    localparam int HOLD = 10;
    logic           core_clk, nrst, cmd_valid, cmd_ready, cmd_chan, jump_valid, jump_taken;
    logic [5:0]     cmd_func;
    logic [1:0]     cmd_desig, in_ack, out_ack;
    logic           q_wr_valid, rx_valid, rx_ready;
    tcpio_word_type q_wr_data, q_value, rx_data, ch1_in_data, ch1_out_data, d;
    tcpio_char_type ch0_in_data, ch0_out_data;
    logic           ch0_in_req, ch0_intr, ch0_out_req, ch0_in_ack, ch0_out_ack, ch0_func_line;
    logic           ch1_in_req, ch1_intr, ch1_out_req, ch1_in_ack, ch1_out_ack, ch1_func_line;
    logic [15:0]    rnd;
    tcpio_word_type exp_q[$];
    int             err_total, num_checks, k, n;

    assign in_ack  = {ch1_in_ack, ch0_in_ack};
    assign out_ack = {ch1_out_ack, ch0_out_ack};
    always #25 core_clk = ~core_clk;

    tcpio_top #(.FUNC_HOLD_CYCLES(HOLD), .FIFO_DEPTH(4)) tcpio_top_inst (.*);
    tcpio_equip #(.W(6)) eq0_inst (
        .core_clk, .nrst, .in_ack(ch0_in_ack), .out_ack(ch0_out_ack), .out_data(ch0_out_data),
        .in_data(ch0_in_data), .in_req(ch0_in_req), .intr(ch0_intr), .out_req(ch0_out_req));
    tcpio_equip #(.W(15)) eq1_inst (
        .core_clk, .nrst, .in_ack(ch1_in_ack), .out_ack(ch1_out_ack), .out_data(ch1_out_data),
        .in_data(ch1_in_data), .in_req(ch1_in_req), .intr(ch1_intr), .out_req(ch1_out_req));

    // ============================================================
    // expectations and shared tasks
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // a channel-zero word arrives zero-extended
    function automatic tcpio_word_type in_word(input logic ch, input logic [15:0] raw);
        return ch ? raw[14:0] : {9'h000, raw[5:0]};
    endfunction : in_word

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic issue(input logic [5:0] f, input logic [1:0] j, input logic ch);
        int w = 0;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_func  <= f;
        cmd_desig <= j;
        cmd_chan  <= ch;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && w < 200) begin
            @(negedge core_clk);
            w++;
        end
        chk("cmd_ready wait", 15'h0001, 15'(cmd_ready));
        if (w >= 200) close_out();
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask : issue

    task automatic jump(input logic [1:0] j, input logic ch, input logic exp);
        issue(`TCPIO_F_JUMP, j, ch);
        @(negedge core_clk);
        chk("jump_valid", 15'h0001, 15'(jump_valid));
        chk("jump_taken", 15'(exp), 15'(jump_taken));
    endtask : jump

    task automatic wait_low(input logic is_out, input logic ch);
        int w = 0;
        while ((is_out ? out_ack[ch] : in_ack[ch]) !== 1'b0 && w < 40) begin
            @(negedge core_clk);
            w++;
        end
        chk("ack release", 15'h0000, 15'(is_out ? out_ack[ch] : in_ack[ch]));
        if (w >= 40) close_out();
    endtask : wait_low

    task automatic put(input logic ch, input tcpio_word_type w, input int mode);
        if (ch) eq1_inst.put_word(w, mode);
        else eq0_inst.put_word(w[5:0], mode);
        repeat (4) @(posedge core_clk);
    endtask : put

    task automatic load_in(input logic ch, input tcpio_word_type w);
        issue(`TCPIO_F_XFER, `TCPIO_J_IN, ch);
        @(negedge core_clk);
        chk("in_ack", 15'h0001, 15'(in_ack[ch]));
        chk("q after input", w, q_value);
    endtask : load_in

    task automatic write_q(input tcpio_word_type w);
        @(posedge core_clk);
        q_wr_valid <= 1'b1;
        q_wr_data  <= w;
        @(posedge core_clk);
        q_wr_valid <= 1'b0;
        @(negedge core_clk);
        chk("ch1 data", w, ch1_out_data);
        chk("ch0 data", 15'(w[5:0]), 15'(ch0_out_data));
    endtask : write_q

    // ============================================================
    // main sequence
    initial begin
        core_clk   = 1'b0;
        nrst       = 1'b0;
        cmd_valid  = 1'b0;
        cmd_func   = 6'h00;
        cmd_desig  = 2'h0;
        cmd_chan   = 1'b0;
        q_wr_valid = 1'b0;
        q_wr_data  = 15'h0000;
        rx_ready   = 1'b0;
        err_total  = 0;
        num_checks = 0;
        rnd        = 16'h26A3;
        repeat (2) @(posedge core_clk);
        chk("reset outputs", 15'h0001, 15'({in_ack, out_ack, ch0_func_line, ch1_func_line, jump_valid, cmd_ready}));
        chk("reset q", 15'h0000, q_value);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (k = 0; k < 4; k++) jump(2'(k), k[0], k != 3);
        issue(6'h05, `TCPIO_J_IN, 1'b1);
        @(negedge core_clk);
        chk("unknown code", 15'h0000, 15'({in_ack, out_ack, rx_valid}) | q_value);
        // input words fill the buffer while the processor side stalls
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            d = (k == 3) ? 15'h7FFF : in_word(k[0], rnd);
            eq0_inst.lag = 6 * k[1];
            eq1_inst.lag = 6 * k[1];
            put(k[0], d, 0);
            jump(`TCPIO_J_IN, k[0], 1'b0);
            load_in(k[0], d);
            chk("other in_ack", 15'h0000, 15'(in_ack[~k[0]]));
            exp_q.push_back(d);
            if (k >= 2) jump(`TCPIO_J_IN, k[0], 1'b1);
            wait_low(1'b0, k[0]);
        end
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_func  <= `TCPIO_F_XFER;
        cmd_desig <= `TCPIO_J_IN;
        @(negedge core_clk);
        chk("refused when full", 15'h0000, 15'(cmd_ready));
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        rx_ready  <= 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge core_clk);
            if (rx_valid === 1'b1) chk("rx_data", exp_q[n++], rx_data);
        end
        chk("rx count", 15'h0004, 15'(n));
        // interrupt, then an emergency switch from a pending request
        rnd = lfsr(rnd);
        put(1'b0, in_word(1'b0, rnd), 1);
        jump(`TCPIO_J_INTR, 1'b0, 1'b0);
        jump(`TCPIO_J_IN, 1'b0, 1'b1);
        load_in(1'b0, in_word(1'b0, rnd));
        wait_low(1'b0, 1'b0);
        put(1'b1, 15'h1234, 0);
        put(1'b1, in_word(1'b1, rnd), 2);
        jump(`TCPIO_J_INTR, 1'b1, 1'b0);
        load_in(1'b1, in_word(1'b1, rnd));
        wait_low(1'b0, 1'b1);
        // output words, prompt and slow equipment
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            eq0_inst.lag = 6 * k[1];
            eq1_inst.lag = 6 * k[1];
            write_q(rnd[14:0]);
            jump(`TCPIO_J_OUT, k[0], 1'b1);
            if (k[0]) eq1_inst.want_word();
            else eq0_inst.want_word();
            repeat (4) @(posedge core_clk);
            jump(`TCPIO_J_OUT, k[0], 1'b0);
            issue(`TCPIO_F_XFER, `TCPIO_J_OUT, k[0]);
            @(negedge core_clk);
            chk("out_ack", 15'h0001 << k[0], 15'(out_ack));
            if (k >= 2) jump(`TCPIO_J_OUT, k[0], 1'b1);
            wait_low(1'b1, k[0]);
            chk("word received", k[0] ? rnd[14:0] : 15'(rnd[5:0]),
                k[0] ? eq1_inst.got : 15'(eq0_inst.got));
        end
        // function commands on both channels
        write_q(15'h0010);
        issue(`TCPIO_F_XFER, `TCPIO_J_FUNC, 1'b0);
        @(negedge core_clk);
        chk("ch0 strobe", 15'h0050, 15'({ch0_func_line, ch0_out_data}));
        @(negedge core_clk);
        chk("ch0 strobe end", 15'h0000, 15'({ch0_func_line, ch1_func_line}));
        issue(`TCPIO_F_XFER, `TCPIO_J_FUNC, 1'b1);
        n = 0;
        repeat (3 * HOLD) begin
            @(negedge core_clk);
            if (ch1_func_line === 1'b1) n++;
            if (ch1_func_line === 1'b1) chk("ready while held", 15'h0000, 15'(cmd_ready));
        end
        chk("ch1 line length", 15'(HOLD), 15'(n));
        chk("ready after hold", 15'h0001, 15'(cmd_ready));
        close_out();
    end
endmodule : tcpio_top_bench

`default_nettype wire
